// ### inc/io_alloc_cfg.svh
/*
 * Register offsets, reset values and selection codes for the I/O allocation block.
 * Assumes an 8-bit APB byte address; every register is one aligned 32-bit word.
 */
`ifndef IO_ALLOC_CFG_SVH
`define IO_ALLOC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_INPUT_ROUTE_FORWARD_TRAVEL 8'h00
`define OFS_INPUT_ROUTE_LATCH_HOMING   8'h04
`define OFS_OUTPUT_ROUTE_GROUP_A       8'h08
`define OFS_OUTPUT_ROUTE_GROUP_B       8'h0c
`define OFS_OUTPUT_ROUTE_APPROACH      8'h10
`define OFS_OUTPUT_ROUTE_MAINTENANCE   8'h14
`define OFS_OUTPUT_ROUTE_BRAKE_REQUEST 8'h18
`define OFS_OUTPUT_ROUTE_ZONE_ENTRIES  8'h1c
`define OFS_OUTPUT_ROUTE_ZONE_NUMBER   8'h20
`define OFS_OUTPUT_POLARITY_LOW        8'h24
`define OFS_OUTPUT_POLARITY_HIGH       8'h28
`define OFS_APPLY                      8'h2c
`define OFS_STATUS                     8'h30

// ****************************************
// Sizes and reset values
// ****************************************
`define NUM_CFG        11
`define NUM_IN_FUNC    8
`define NUM_OUT_FUNC   16
`define NUM_PAIRS      5
`define RST_IN_ROUTE   16'h8888
`define RST_GROUP_B    16'h0100
`define RST_ROUTE      16'h0000
`define IDX_IN_TRAVEL  4'h0
`define IDX_GROUP_B    4'h3
`define IDX_POL_LOW    4'h9
`define IDX_POL_HIGH   4'ha

// ****************************************
// Input selection codes
// ****************************************
`define SEL_NORM_MAX   4'h6
`define SEL_FORCE_ON   4'h7
`define SEL_FORCE_OFF  4'h8
`define SEL_INV_BASE   4'h9

`endif

// ### inc/io_alloc_pkg.sv
/*
 * Types shared by the I/O allocation block.
 * Assumes the constants header is compiled alongside.
 */
package io_alloc_pkg;

    typedef logic [3:0]  in_sel_t;
    typedef logic [3:0]  out_sel_t;
    typedef logic [15:0] cfg_word_t;

endpackage : io_alloc_pkg

// ### src/io_signal_allocation.sv
/*
 * Input and output signal allocation: routes contact inputs to input functions
 * and ORs output functions onto five output pin pairs, configured over APB.
 * Assumes pins and function levels are synchronous to core_clk.
 */
// Added by the designer: the APB slave port and the register offsets.
// Behaviour
// - Codes 0 to 6 read that pin; slash functions active closed, others open.
// - Codes 9 to F read the same pins with inverted polarity.
// - Code 7 holds function active; edge-evaluated functions held inactive.
// - Code 8 holds function inactive, for unused functions.
// - Output functions not evaluated in the present mode count as off.
// - Several output functions on one pair drive the OR of them.
// - Output code 0 disables, 1 to 5 pick pairs; brake defaults to 1.
// - Group A holds four status outputs, group B torque, speed, brake, warning.
// - One polarity bit per pair; 1 inverts; all default normal.
// - Brake is negative logic by default; reversing needs verified safe wiring.
// - Functions sharing one input circuit all follow that circuit.
`timescale 1ns/1ps
`include "io_alloc_cfg.svh"

module io_signal_allocation (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic [7:0]                paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [6:0]                in_contact,
    input  wire logic [`NUM_OUT_FUNC-1:0]  out_func_level,
    input  wire logic [`NUM_OUT_FUNC-1:0]  out_func_evaluated,
    output logic      [`NUM_IN_FUNC-1:0]   in_func_state,
    output logic      [`NUM_PAIRS-1:0]     out_pair
);

    // ****************************************
    // Function attributes
    // ****************************************
    // Input order: forward travel, reverse travel, forward cap, reverse cap, homing, latch 1..3
    localparam logic [7:0] SLASH_FUNC = 8'hfc;
    localparam logic [7:0] EDGE_FUNC  = 8'he0;
    // Output function j takes its code from register OUT_REG[j], nibble OUT_NIB[j]
    localparam int OUT_REG [16] = '{2, 2, 2, 2, 3, 3, 3, 3, 4, 5, 6, 7, 7, 7, 7, 8};
    localparam int OUT_NIB [16] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 1, 0, 1, 2, 3, 0};

    io_alloc_pkg::cfg_word_t stage [`NUM_CFG];
    io_alloc_pkg::cfg_word_t act   [`NUM_CFG];

    function automatic io_alloc_pkg::cfg_word_t rst_val(input int idx);
        if (idx < 2) begin
            return `RST_IN_ROUTE;
        end else if (idx == int'(`IDX_GROUP_B)) begin
            return `RST_GROUP_B;
        end else begin
            return `RST_ROUTE;
        end
    endfunction : rst_val

    // ****************************************
    // APB address decode
    // ****************************************
    logic       hit_cfg;
    logic       hit_apply;
    logic       hit_status;
    logic [3:0] cfg_idx;
    logic       setup;
    logic       done;
    logic       bad_access;

    always_comb begin
        hit_cfg    = 1'b0;
        hit_apply  = 1'b0;
        hit_status = 1'b0;
        cfg_idx    = 4'h0;
        if (paddr < `OFS_APPLY && paddr[1:0] == 2'b00) begin
            hit_cfg = 1'b1;
            cfg_idx = paddr[5:2];
        end else if (paddr == `OFS_APPLY) begin
            hit_apply = 1'b1;
        end else if (paddr == `OFS_STATUS) begin
            hit_status = 1'b1;
        end
    end

    assign setup      = psel & ~penable & ~pready;
    assign done       = psel & penable & pready;
    assign bad_access = ~(hit_cfg | hit_apply | hit_status) | (hit_status & pwrite);

    // ****************************************
    // APB answer
    // ****************************************
    // Answer is prepared in the setup cycle so every bus output comes from a flop
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pslverr <= bad_access;
            if (hit_cfg && !pwrite) begin
                prdata <= {16'h0000, stage[cfg_idx]};
            end else if (hit_status && !pwrite) begin
                prdata <= {19'h00000, out_pair, in_func_state};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else if (done) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Staging and active configuration
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < `NUM_CFG; i++) begin
                stage[i] <= rst_val(i);
            end
        end else if (done && pwrite && hit_cfg) begin
            stage[cfg_idx] <= pwdata[15:0];
        end
    end

    // Staged writes are invisible until apply, so no half-written map reaches a pin
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < `NUM_CFG; i++) begin
                act[i] <= rst_val(i);
            end
        end else if (done && pwrite && hit_apply) begin
            for (int i = 0; i < `NUM_CFG; i++) begin
                act[i] <= stage[i];
            end
        end
    end

    // ****************************************
    // Input functions
    // ****************************************
    logic [`NUM_IN_FUNC-1:0] next_in_func;

    // Latch inputs on the top three pins are not blocked here; software keeps that off
    for (genvar i = 0; i < `NUM_IN_FUNC; i++) begin : g_in
        io_alloc_pkg::in_sel_t sel;
        logic [3:0]            inv_pin;
        assign sel     = act[i / 4][4 * (i % 4) +: 4];
        assign inv_pin = sel - `SEL_INV_BASE;

        always_comb begin
            if (sel <= `SEL_NORM_MAX) begin
                next_in_func[i] = in_contact[sel[2:0]] ^ ~SLASH_FUNC[i];
            end else if (sel == `SEL_FORCE_ON) begin
                next_in_func[i] = ~EDGE_FUNC[i];
            end else if (sel == `SEL_FORCE_OFF) begin
                next_in_func[i] = 1'b0;
            end else begin
                next_in_func[i] = in_contact[inv_pin[2:0]] ^ SLASH_FUNC[i];
            end
        end

        a_normal_pol: assert property (@(posedge core_clk) disable iff (!resetn)
            (resetn && sel <= `SEL_NORM_MAX) ##1 $stable(sel)
            |-> in_func_state[i] == ($past(in_contact[sel[2:0]]) ^ ~SLASH_FUNC[i]))
            else $error("normal input polarity wrong");

        a_invert_pol: assert property (@(posedge core_clk) disable iff (!resetn)
            (resetn && sel >= `SEL_INV_BASE) ##1 $stable(sel)
            |-> in_func_state[i] == ($past(in_contact[inv_pin[2:0]]) ^ SLASH_FUNC[i]))
            else $error("inverted input polarity wrong");

        a_force_on: assert property (@(posedge core_clk) disable iff (!resetn)
            (resetn && sel == `SEL_FORCE_ON) [*2] |-> in_func_state[i] == ~EDGE_FUNC[i])
            else $error("forced input level wrong");

        a_force_off: assert property (@(posedge core_clk) disable iff (!resetn)
            (resetn && sel == `SEL_FORCE_OFF) [*2] |-> !in_func_state[i])
            else $error("unused input not inactive");
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            in_func_state <= '0;
        end else begin
            in_func_state <= next_in_func;
        end
    end

    // ****************************************
    // Output pin pairs
    // ****************************************
    logic [`NUM_OUT_FUNC-1:0] func_on;
    logic [`NUM_PAIRS-1:0]    pair_pol;
    logic [`NUM_PAIRS-1:0]    next_out_pair;

    assign func_on = out_func_level & out_func_evaluated;

    for (genvar p = 0; p < `NUM_PAIRS; p++) begin : g_pair
        logic [`NUM_OUT_FUNC-1:0] routed;
        for (genvar j = 0; j < `NUM_OUT_FUNC; j++) begin : g_fn
            io_alloc_pkg::out_sel_t osel;
            assign osel      = act[OUT_REG[j]][4 * OUT_NIB[j] +: 4];
            assign routed[j] = (osel == 4'(p + 1));
        end

        // Brake defaults to negative logic; inverting it loses fail-safe on a broken wire
        if (p < 4) begin : g_lo
            assign pair_pol[p] = act[`IDX_POL_LOW][4 * p];
        end else begin : g_hi
            assign pair_pol[p] = act[`IDX_POL_HIGH][0];
        end

        assign next_out_pair[p] = (|(func_on & routed)) ^ pair_pol[p];

        a_pair_or: assert property (@(posedge core_clk) disable iff (!resetn)
            resetn ##1 $stable(routed) && $stable(pair_pol[p])
            |-> out_pair[p] == ((|($past(func_on) & routed)) ^ pair_pol[p]))
            else $error("output pair is not the OR of its functions");

        a_unevaluated: assert property (@(posedge core_clk) disable iff (!resetn)
            (resetn && !(|(out_func_evaluated & routed))) ##1 $stable(routed) && $stable(pair_pol[p])
            |-> out_pair[p] == pair_pol[p])
            else $error("unevaluated function drove a pair");

        a_pair_unrouted: assert property (@(posedge core_clk) disable iff (!resetn)
            (resetn && !(|routed)) ##1 $stable(routed) && $stable(pair_pol[p])
            |-> out_pair[p] == pair_pol[p])
            else $error("pair with no routed function not idle");
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            out_pair <= '0;
        end else begin
            out_pair <= next_out_pair;
        end
    end

    // ****************************************
    // Bus and configuration checks
    // ****************************************
    a_apply_atomic: assert property (@(posedge core_clk) disable iff (!resetn)
        (act[`IDX_POL_LOW] != $past(act[`IDX_POL_LOW])) || (act[`IDX_GROUP_B] != $past(act[`IDX_GROUP_B]))
        |-> $past(done && pwrite && hit_apply))
        else $error("active map changed without apply");

    a_brake_default: assert property (@(posedge core_clk)
        $rose(resetn) |-> act[`IDX_GROUP_B] == `RST_GROUP_B && act[`IDX_POL_LOW] == `RST_ROUTE)
        else $error("brake default route lost");

    a_pready_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        setup |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");

    a_unmapped_err: assert property (@(posedge core_clk) disable iff (!resetn)
        (setup && !(hit_cfg || hit_apply || hit_status)) |=> pslverr && pready)
        else $error("unmapped access not flagged");

    a_status_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (setup && hit_status && pwrite) |=> pslverr && pready)
        else $error("status write not refused");

    a_err_with_ready: assert property (@(posedge core_clk) disable iff (!resetn)
        pslverr |-> pready)
        else $error("error flag outside access cycle");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!resetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data not cleared between accesses");

    a_cfg_readback: assert property (@(posedge core_clk) disable iff (!resetn)
        (setup && hit_cfg && !pwrite) |=> prdata == {16'h0000, $past(stage[cfg_idx])})
        else $error("read data is not the staged word");

    a_stage_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (done && pwrite && hit_cfg) |=> stage[$past(cfg_idx)] == $past(pwdata[15:0]))
        else $error("staged write lost");

    a_apply_copy: assert property (@(posedge core_clk) disable iff (!resetn)
        (done && pwrite && hit_apply) |=> act[`IDX_GROUP_B] == $past(stage[`IDX_GROUP_B])
        && act[`IDX_POL_HIGH] == $past(stage[`IDX_POL_HIGH]))
        else $error("apply did not copy staging");

    a_act_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        !(done && pwrite && hit_apply) |=> $stable(act[0]) && $stable(act[1]) && $stable(act[`IDX_POL_HIGH]))
        else $error("active map moved without apply");

endmodule : io_signal_allocation

// ### test/contact_bank.sv
/*
 * Far-side model: a bank of seven dry contacts wired to the input pins.
 * Assumes the bench requests contact states just after a rising edge.
 */
`timescale 1ns/1ps

// ****************************************
// Contact bank
// ****************************************
module contact_bank (
    input  wire logic [6:0] closed_req,
    output logic      [6:0] in_contact
);
    // Plain wiring: no bounce, so settings are judged on clean levels only
    assign in_contact = closed_req;
endmodule : contact_bank

// ### test/io_signal_allocation_tb.sv
/*
 * Self-checking bench for the I/O allocation block: APB set-up, input routing table, output OR and polarity.
 * Assumes the constants header and package are compiled first.
 */
`timescale 1ns/1ps
`include "io_alloc_cfg.svh"

module io_signal_allocation_tb;
    typedef struct packed {logic [15:0] r0; logic [15:0] r1; logic [6:0] c; logic [7:0] f;} row_s;
    logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    logic [6:0]  closed_req, in_contact;
    logic [15:0] lvl, evl;
    logic [7:0]  in_func_state;
    logic [4:0]  out_pair;
    int          n_fail, checked;
    // Latch inputs kept off pins 4 to 6 in every row
    row_s rows [5] = '{'{16'h3210, 16'h3210, 7'h05, 8'h56}, '{16'hcba9, 16'hcba9, 7'h05, 8'ha9},
                       '{16'h7777, 16'h7777, 7'h05, 8'h1f}, '{16'h8888, 16'h8888, 7'h7f, 8'h00},
                       '{16'h6d54, 16'h8888, 7'h10, 8'h02}};

    contact_bank bank (.closed_req(closed_req), .in_contact(in_contact));
    io_signal_allocation dut (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_contact(in_contact), .out_func_level(lvl), .out_func_evaluated(evl),
        .in_func_state(in_func_state), .out_pair(out_pair));

    always #4 core_clk = ~core_clk;

    // ****************************************
    // Tasks
    // ****************************************
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        // Wait on the slave; only the bound ends a hang
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata; err = pslverr;
        if (pready !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t apb wait bound ran out", $time);
        end
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task wrap_up;
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        core_clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        closed_req = 7'h7f; lvl = 16'h0040; evl = 16'hffff; n_fail = 0; checked = 0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        tick(2);
        chk(in_func_state, 8'h00, "reset inputs");
        chk(out_pair, 5'h01, "reset brake pair");
        apb(`OFS_INPUT_ROUTE_FORWARD_TRAVEL, 0, 0);
        chk(rd, 32'h8888, "reset input route");
        apb(`OFS_OUTPUT_ROUTE_GROUP_B, 0, 0);
        chk(rd, 32'h0100, "reset group b");
        foreach (rows[i]) begin
            apb(`OFS_INPUT_ROUTE_FORWARD_TRAVEL, 1, {16'hffff, rows[i].r0});
            apb(`OFS_INPUT_ROUTE_LATCH_HOMING, 1, rows[i].r1);
            closed_req <= rows[i].c;
            apb(`OFS_APPLY, 1, 0);
            tick(2);
            chk(in_func_state, rows[i].f, "input row");
        end
        apb(`OFS_INPUT_ROUTE_FORWARD_TRAVEL, 0, 0);
        chk(rd, 32'h6d54, "upper half dropped");
        apb(`OFS_OUTPUT_ROUTE_GROUP_A, 1, 16'h1111);
        apb(`OFS_OUTPUT_ROUTE_GROUP_B, 1, 16'h0000);
        apb(`OFS_APPLY, 1, 0);
        lvl <= 16'h0005;
        tick(2);
        chk(out_pair, 5'h01, "or onto pair");
        @(posedge core_clk) evl <= ~16'h0005;
        tick(2);
        chk(out_pair, 5'h00, "unevaluated off");
        @(posedge core_clk) evl <= 16'hffff;
        apb(`OFS_OUTPUT_ROUTE_GROUP_A, 1, 16'h4321);
        apb(`OFS_OUTPUT_ROUTE_GROUP_B, 1, 16'h0005);
        apb(`OFS_APPLY, 1, 0);
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk) lvl <= 16'h0001 << i;
            tick(2);
            chk(out_pair, 5'h01 << i, "pair order");
        end
        @(posedge core_clk) lvl <= 16'h0000;
        apb(`OFS_OUTPUT_POLARITY_LOW, 1, 16'h1010);
        apb(`OFS_OUTPUT_POLARITY_HIGH, 1, 16'h0001);
        tick(2);
        chk(out_pair, 5'h00, "staged polarity idle");
        apb(`OFS_APPLY, 1, 0);
        tick(2);
        chk(out_pair, 5'h1a, "polarity reversed");
        apb(`OFS_STATUS, 0, 0);
        chk(rd, 32'h1a02, "status view");
        apb(`OFS_STATUS, 1, 32'hffff);
        chk(err, 1'b1, "status write refused");
        apb(8'h3c, 0, 0);
        chk(err, 1'b1, "unmapped read");
        wrap_up();
    end

    // Run needs about 140 cycles; the watchdog allows over forty times that
    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule : io_signal_allocation_tb
